/* i2c_status_and_data_regs_tb_top.sv */
`default_nettype none
module i2c_status_and_data_regs_tb_top
  import i2csr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, shift_empty, irq, tx_byte_valid;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, m;
  logic start_det, stop_det, nack_det, addr_match_det, alert_det, timeout_det, check_error_det;
  logic over_under_det, arb_lost_det, bus_error_det, byte_done, rx_byte_valid, tx_shift_load, check_valid;
  logic reload_enable, auto_stop_enable, slave_byte_control, stretch_disable, master_mode;
  logic [7:0] rx_byte_data, check_data, tx_byte, d, byte_count;
  logic [15:0] ev;
  int num_errors, compares, cyc;
  logic [7:0] ra[5] = '{ADDR_STATUS, ADDR_CHECK, ADDR_RX, ADDR_TX, 8'h40};
  int flg[9] = '{B_STOP, B_NACK, B_ADDR, B_ALERT, B_TMOUT, B_PECERR, B_OVUN, B_ARLOST, B_BUS_ERROR_FLAG};
  logic [31:0] rc[3] = '{32'h0000_0001, 32'h0000_0011, 32'h0000_0005};
  logic [31:0] re[3] = '{32'h0000_0000, 32'h0000_0080, 32'h0000_0080};
  i2csr_top uut (.*, .hready(hreadyout));
  i2csr_link_model link (.*);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic give_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // A hang is cut off well beyond the few hundred cycles the tests need.
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  // One single AHB-Lite transfer; ready is judged at rising edges, where its pre-edge value is the sampled one.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, WORD_ZERO);
    chk(n, e, rd);
  endtask
  task automatic fire(input logic [15:0] p);
    ev <= p;
    @(posedge hclk);
    ev <= 16'h0000;
  endtask
  initial begin
    {hresetn, hsel, hwrite, shift_empty, num_errors, compares, cyc} = '0;
    {htrans, haddr, hwdata, ev, d} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, and an unmapped word that ignores writes.
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    foreach (ra[i]) rchk("reset word", ra[i], WORD_ZERO);
    chk("resp", WORD_ZERO, {31'h0000_0000, hresp});
    $display("test reset done");
    // Sticky flags survive status writes and clear-zero, and go on clear-one.
    foreach (flg[i]) begin
      m = 32'h0000_0001 << flg[i];
      fire(m[15:0]);
      rchk("flag set", ADDR_STATUS, m);
      bus(1'b1, ADDR_STATUS, 32'h0000_FFFC);
      rchk("status write", ADDR_STATUS, m);
      bus(1'b1, ADDR_CLEAR, WORD_ZERO);
      rchk("clear zero", ADDR_STATUS, m);
      bus(1'b1, ADDR_CLEAR, m);
      rchk("clear one", ADDR_STATUS, WORD_ZERO);
    end
    $display("test flags done");
    // Done flag against shifter, auto stop and bus conditions; busy flag.
    shift_empty <= 1'b1;
    @(posedge hclk);
    rchk("done set", ADDR_STATUS, 32'h0000_0040);
    shift_empty <= 1'b0;
    fire(16'h8000);
    rchk("start", ADDR_STATUS, 32'h0000_8000);
    bus(1'b1, ADDR_CTRL, 32'h0000_0002);
    shift_empty <= 1'b1;
    rchk("done auto stop", ADDR_STATUS, 32'h0000_8000);
    bus(1'b1, ADDR_CTRL, WORD_ZERO);
    @(posedge hclk);
    rchk("done again", ADDR_STATUS, 32'h0000_8040);
    shift_empty <= 1'b0;
    fire(16'h0020);
    rchk("stop", ADDR_STATUS, 32'h0000_0020);
    bus(1'b1, ADDR_CLEAR, 32'h0000_0020);
    $display("test done busy done");
    // Reload wait needs master mode or slave byte control.
    foreach (rc[i]) begin
      bus(1'b1, ADDR_CTRL, rc[i]);
      bus(1'b1, ADDR_COUNT, 32'h0000_0001);
      fire(16'h0080);
      @(posedge hclk);
      chk("count", 32'h0000_0000, {24'h00_0000, byte_count});
      rchk("reload wait", ADDR_STATUS, re[i]);
      bus(1'b1, ADDR_COUNT, 32'h0000_0002);
      rchk("reload cleared", ADDR_STATUS, WORD_ZERO);
    end
    bus(1'b1, ADDR_CTRL, WORD_ZERO);
    $display("test reload done");
    // Received byte, its flag, and the check byte.
    d <= 8'hA5;
    fire(16'h0004);
    rchk("rx full", ADDR_STATUS, 32'h0000_0004);
    rchk("rx byte", ADDR_RX, 32'h0000_00A5);
    rchk("rx read", ADDR_STATUS, WORD_ZERO);
    d <= 8'h3C;
    fire(16'h0040);
    rchk("check byte", ADDR_CHECK, 32'h0000_003C);
    $display("test receive done");
    // Transmit register, request and empty flags, flush.
    bus(1'b1, ADDR_TX, 32'h0000_005A);
    @(posedge hclk);
    chk("tx out", 32'h0000_015A, {23'h00_0000, tx_byte_valid, tx_byte});
    fire(16'h0002);
    rchk("tx moved", ADDR_STATUS, 32'h0000_0003);
    bus(1'b1, ADDR_TX, 32'h0000_00C3);
    rchk("tx refill", ADDR_STATUS, WORD_ZERO);
    bus(1'b1, ADDR_STATUS, 32'h0000_0002);
    rchk("tx req stretched", ADDR_STATUS, WORD_ZERO);
    bus(1'b1, ADDR_CTRL, 32'h0000_0008);
    bus(1'b1, ADDR_STATUS, 32'h0000_0002);
    rchk("tx req set", ADDR_STATUS, 32'h0000_0002);
    bus(1'b1, ADDR_STATUS, 32'h0000_0001);
    rchk("tx flush", ADDR_STATUS, 32'h0000_0003);
    chk("tx flushed", WORD_ZERO, {31'h0000_0000, tx_byte_valid});
    $display("test transmit done");
    // Interrupt raised, masked and cleared.
    bus(1'b1, ADDR_IRQ_STATUS, 32'h0000_FFFF);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0010);
    fire(16'h0010);
    @(posedge hclk);
    rchk("event", ADDR_IRQ_STATUS, 32'h0000_0010);
    chk("irq on", 32'h0000_0001, {31'h0000_0000, irq});
    bus(1'b1, ADDR_IRQ_MASK, WORD_ZERO);
    repeat (2) @(posedge hclk);
    chk("irq masked", WORD_ZERO, {31'h0000_0000, irq});
    bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0010);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h0000_0010);
    repeat (2) @(posedge hclk);
    chk("irq cleared", WORD_ZERO, {31'h0000_0000, irq});
    $display("test interrupt done");
    give_verdict();
  end
endmodule
`default_nettype wire

/* i2csr_link_model.sv */
`default_nettype none
// Bus-facing side of the controller; each bit of ev is an event at its status bit position.
module i2csr_link_model
  import i2csr_pkg::*;
(
  input wire logic [FLAG_W-1:0] ev,
  input wire logic [7:0] d,
  output logic start_det,
  output logic stop_det,
  output logic nack_det,
  output logic addr_match_det,
  output logic alert_det,
  output logic timeout_det,
  output logic check_error_det,
  output logic over_under_det,
  output logic arb_lost_det,
  output logic bus_error_det,
  output logic byte_done,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte_data,
  output logic tx_shift_load,
  output logic check_valid,
  output logic [7:0] check_data
);
  // Pulses pass straight through; data lines invert outside their strobe so stale bytes never match.
  assign start_det = ev[B_BUSY];
  assign stop_det = ev[B_STOP];
  assign nack_det = ev[B_NACK];
  assign addr_match_det = ev[B_ADDR];
  assign alert_det = ev[B_ALERT];
  assign timeout_det = ev[B_TMOUT];
  assign check_error_det = ev[B_PECERR];
  assign over_under_det = ev[B_OVUN];
  assign arb_lost_det = ev[B_ARLOST];
  assign bus_error_det = ev[B_BUS_ERROR_FLAG];
  assign byte_done = ev[B_RELOAD];
  assign rx_byte_valid = ev[B_RXFULL];
  assign rx_byte_data = ev[B_RXFULL] ? d : ~d;
  assign tx_shift_load = ev[B_TXREQ];
  assign check_valid = ev[B_DONE];
  assign check_data = ev[B_DONE] ? d : ~d;
endmodule
`default_nettype wire

/* i2csr_pkg.sv */
`default_nettype none
package i2csr_pkg;
  // Byte addresses of the register words on the bus.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_CHECK = 8'h08;
  localparam logic [7:0] ADDR_RX = 8'h0C;
  localparam logic [7:0] ADDR_TX = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

  // Bit positions shared by the status, clear, event and mask words.
  localparam int B_BUSY = 15;
  localparam int B_ALERT = 13;
  localparam int B_TMOUT = 12;
  localparam int B_PECERR = 11;
  localparam int B_OVUN = 10;
  localparam int B_ARLOST = 9;
  localparam int B_BUS_ERROR_FLAG = 8;
  localparam int B_RELOAD = 7;
  localparam int B_DONE = 6;
  localparam int B_STOP = 5;
  localparam int B_NACK = 4;
  localparam int B_ADDR = 3;
  localparam int B_RXFULL = 2;
  localparam int B_TXREQ = 1;
  localparam int B_TXEMPTY = 0;
  localparam int FLAG_W = 16;

  // Bit positions in the control word.
  localparam int C_RELOAD_EN = 0;
  localparam int C_AUTOSTOP_EN = 1;
  localparam int C_SLAVE_BYTE_CTRL = 2;
  localparam int C_STRETCH_DIS = 3;
  localparam int C_MASTER = 4;
  localparam int CTRL_W = 5;

  // Reset values.
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Bus encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

/* i2csr_sr_checker.sv */
`default_nettype none
module i2csr_sr_checker
  import i2csr_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic byte_done,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte_data,
  input wire logic tx_shift_load,
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_valid,
  input wire logic [CNT_W-1:0] byte_count,
  input wire logic reload_enable,
  input wire logic auto_stop_enable,
  input wire logic slave_byte_control,
  input wire logic stretch_disable,
  input wire logic master_mode,
  input wire logic irq
);
  logic dv;
  logic dw;
  logic [7:0] da;
  logic [7:0] rx_q;
  // Remember each accepted address phase, since writes land only at the end of the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv <= 1'b0;
      dw <= 1'b0;
      da <= 8'h00;
    end else begin
      dv <= hsel && htrans[1] && hready;
      dw <= hwrite;
      da <= haddr[7:0];
    end
  end
  // Shadow of the receive register, so a read can be judged without the design's state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_q <= 8'h00;
    end else if (rx_byte_valid) begin
      rx_q <= rx_byte_data;
    end
  end
  // Data-phase decodes.
  wire logic wr_tx = dv && dw && da == ADDR_TX;
  wire logic wr_sts = dv && dw && da == ADDR_STATUS;
  wire logic wr_cnt = dv && dw && da == ADDR_COUNT;
  wire logic wr_ctl = dv && dw && da == ADDR_CTRL;
  wire logic wr_msk = dv && dw && da == ADDR_IRQ_MASK;
  wire logic rd_rx = dv && !dw && da == ADDR_RX;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_TX_WRITE: assert property (wr_tx |=> tx_byte_valid && tx_byte == $past(hwdata[7:0]))
    else $error("transmit byte not taken");
  AST_TX_LOAD: assert property (tx_shift_load && !wr_tx |=> !tx_byte_valid)
    else $error("transmit register still full after load");
  AST_TX_FLUSH: assert property (wr_sts && hwdata[B_TXEMPTY] |=> !tx_byte_valid)
    else $error("transmit register not flushed");
  AST_COUNT_WRITE: assert property (wr_cnt && !byte_done |=> byte_count == $past(hwdata[CNT_W-1:0]))
    else $error("byte count write lost");
  AST_COUNT_STEP: assert property (byte_done && byte_count != 0 && !wr_cnt |=> byte_count == $past(byte_count) - 1'b1)
    else $error("byte count did not step down");
  AST_CTRL_WRITE: assert property (wr_ctl |=> {master_mode, stretch_disable, slave_byte_control,
    auto_stop_enable, reload_enable} == $past(hwdata[4:0]))
    else $error("control settings not taken");
  AST_IRQ_MASKED: assert property (wr_msk && hwdata[15:0] == 16'h0000 |-> ##2 !irq)
    else $error("interrupt high with all sources masked");
  AST_RX_READ: assert property (rd_rx |-> hrdata == {24'h00_0000, $past(rx_q)})
    else $error("receive read returned wrong byte");
  cover property (wr_cnt);
  cover property (rd_rx);
  cover property (tx_shift_load && tx_byte_valid);
endmodule
bind i2csr_top i2csr_sr_checker #(.CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire

/* i2csr_top.sv */
`default_nettype none
// Contract
// - Reload-wait flag sets at count one, reload on
// - Writing byte count clears reload-wait flag
// - Reload-wait only in master or slave byte-control
// - Done flag: shift empty, no autostop/reload, count zero
// - Done flag clears on START or STOP
// - Stop flag sets on STOP, cleared by software
// - Nack flag sets on missing ack, write-one clears
// - Address flag sets on match, write-one clears
// - Rx-full flag follows unread received byte
// - Tx request when byte moves to shifter
// - Write one makes tx request when unstretched
// - Tx empty flag; write one flushes register
// - Alert, timeout, check-error clear by writing one
// - Over/under, arbitration, bus error clear by one
// - Busy sets on START, clears on STOP
module i2csr_top
  import i2csr_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Inputs from the bus-facing part of the controller: one-cycle event pulses, the shift_empty level and data bytes.
  input wire logic start_det,
  input wire logic stop_det,
  input wire logic nack_det,
  input wire logic addr_match_det,
  input wire logic alert_det,
  input wire logic timeout_det,
  input wire logic check_error_det,
  input wire logic over_under_det,
  input wire logic arb_lost_det,
  input wire logic bus_error_det,
  input wire logic byte_done,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte_data,
  input wire logic tx_shift_load,
  input wire logic shift_empty,
  input wire logic check_valid,
  input wire logic [7:0] check_data,
  // Settings and data toward the bus-facing part, and the interrupt line.
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  output logic [CNT_W-1:0] byte_count,
  output logic reload_enable,
  output logic auto_stop_enable,
  output logic slave_byte_control,
  output logic stretch_disable,
  output logic master_mode,
  output logic irq
);

  // Set wins over clear so that an event coinciding with a clear survives.
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    if (set) begin
      flag_next = 1'b1;
    end else if (clr) begin
      flag_next = 1'b0;
    end else begin
      flag_next = cur;
    end
  endfunction

  // Register state.
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] flags_prev;
  logic [FLAG_W-1:0] irq_status;
  logic [FLAG_W-1:0] irq_mask;
  logic [CTRL_W-1:0] ctrl;
  logic [7:0] receive_byte;
  logic [7:0] check_byte;

  // Data-phase bookkeeping of an accepted write.
  logic wr_pend;
  logic [7:0] wr_addr;

  // Address-phase decode.
  logic accept;
  logic [7:0] a_addr;
  logic rd_accept;

  // Data-phase write strobes and the address-phase receive-read strobe.
  logic wr_status;
  logic wr_clear;
  logic wr_tx;
  logic wr_ctrl;
  logic wr_count;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic rd_rx;

  // Clear-register bits named per flag.
  logic alert_clear;
  logic timeout_clear;
  logic check_error_clear;
  logic over_under_clear;
  logic arb_lost_clear;
  logic bus_error_clear;
  logic stop_seen_clear;
  logic nack_clear;
  logic addr_match_clear;

  // Set terms of the hardware flags.
  logic set_reload;
  logic set_done;
  logic reload_allowed;
  logic next_flag_word;

  // A transfer is taken whenever the bus is ready; this slave stalls only until the first clock after reset.
  assign accept = hsel && (htrans == HTRANS_NONSEQ || htrans == 2'h3) && hready;
  assign a_addr = haddr[7:0];
  assign rd_accept = accept && !hwrite;
  assign rd_rx = rd_accept && (a_addr == ADDR_RX);

  // Data-phase strobes come from the latched address.
  assign wr_status = wr_pend && (wr_addr == ADDR_STATUS);
  assign wr_clear = wr_pend && (wr_addr == ADDR_CLEAR);
  assign wr_tx = wr_pend && (wr_addr == ADDR_TX);
  assign wr_ctrl = wr_pend && (wr_addr == ADDR_CTRL);
  assign wr_count = wr_pend && (wr_addr == ADDR_COUNT);
  assign wr_irq_status = wr_pend && (wr_addr == ADDR_IRQ_STATUS);
  assign wr_irq_mask = wr_pend && (wr_addr == ADDR_IRQ_MASK);

  // Clear bits only act on a one; zeros leave the flags alone.
  assign alert_clear = wr_clear && hwdata[B_ALERT];
  assign timeout_clear = wr_clear && hwdata[B_TMOUT];
  assign check_error_clear = wr_clear && hwdata[B_PECERR];
  assign over_under_clear = wr_clear && hwdata[B_OVUN];
  assign arb_lost_clear = wr_clear && hwdata[B_ARLOST];
  assign bus_error_clear = wr_clear && hwdata[B_BUS_ERROR_FLAG];
  assign stop_seen_clear = wr_clear && hwdata[B_STOP];
  assign nack_clear = wr_clear && hwdata[B_NACK];
  assign addr_match_clear = wr_clear && hwdata[B_ADDR];

  // The reload wait only has meaning for a master or a byte-controlled slave.
  assign reload_allowed = master_mode || slave_byte_control;
  assign set_reload = byte_done && (byte_count == CNT_W'(1)) && reload_enable && reload_allowed;
  // Done is level-driven by an empty shifter at a zero count with no auto stop or reload.
  assign set_done = shift_empty && !auto_stop_enable && !reload_enable && (byte_count == '0);
  assign next_flag_word = 1'b0;

  // The bus never sees an error, and sees a wait state only until the first clock after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Latch the address phase of a write so the data phase can use hwdata.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= accept && hwrite;
      if (accept) begin
        wr_addr <= a_addr;
      end
    end
  end

  // Read data is registered at the address phase so it stands in the data phase.
  // Unmapped addresses read zero; narrow registers read zero above their width.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= WORD_ZERO;
    end else if (rd_accept) begin
      unique case (a_addr)
        ADDR_STATUS: hrdata <= {16'h0000, flags};
        ADDR_CHECK: hrdata <= {24'h00_0000, check_byte};
        ADDR_RX: hrdata <= {24'h00_0000, receive_byte};
        ADDR_TX: hrdata <= {24'h00_0000, tx_byte};
        ADDR_CTRL: hrdata <= {27'h000_0000, ctrl};
        ADDR_COUNT: hrdata <= 32'(byte_count);
        ADDR_IRQ_STATUS: hrdata <= {16'h0000, irq_status};
        ADDR_IRQ_MASK: hrdata <= {16'h0000, irq_mask};
        default: hrdata <= WORD_ZERO;
      endcase
    end
  end

  // Control settings that steer the bus-facing logic.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= hwdata[CTRL_W-1:0];
    end
  end

  assign reload_enable = ctrl[C_RELOAD_EN];
  assign auto_stop_enable = ctrl[C_AUTOSTOP_EN];
  assign slave_byte_control = ctrl[C_SLAVE_BYTE_CTRL];
  assign stretch_disable = ctrl[C_STRETCH_DIS];
  assign master_mode = ctrl[C_MASTER];

  // Byte counter: software loads it, each finished byte counts it down to zero.
  // A load in the same cycle as a finished byte takes the loaded value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_count <= '0;
    end else if (wr_count) begin
      byte_count <= hwdata[CNT_W-1:0];
    end else if (byte_done && (byte_count != '0)) begin
      byte_count <= byte_count - CNT_W'(1);
    end
  end

  // Transmit byte: a software write fills it; a flush leaves the byte and only clears tx_byte_valid.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_byte <= BYTE_RESET;
    end else if (wr_tx) begin
      tx_byte <= hwdata[7:0];
    end
  end

  // Received byte and check byte are captured from the bus-facing logic.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receive_byte <= BYTE_RESET;
      check_byte <= BYTE_RESET;
    end else begin
      if (rx_byte_valid) begin
        receive_byte <= rx_byte_data;
      end
      if (check_valid) begin
        check_byte <= check_data;
      end
    end
  end

  // Bus busy follows START and STOP; STOP wins if both arrive together.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[B_BUSY] <= 1'b0;
    end else if (stop_det) begin
      flags[B_BUSY] <= 1'b0;
    end else if (start_det) begin
      flags[B_BUSY] <= 1'b1;
    end
  end

  // Error and SMBus flags change only by their event or by the clear word.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[B_ALERT] <= 1'b0;
      flags[B_TMOUT] <= 1'b0;
      flags[B_PECERR] <= 1'b0;
      flags[B_OVUN] <= 1'b0;
      flags[B_ARLOST] <= 1'b0;
      flags[B_BUS_ERROR_FLAG] <= 1'b0;
    end else begin
      flags[B_ALERT] <= flag_next(flags[B_ALERT], alert_det, alert_clear);
      flags[B_TMOUT] <= flag_next(flags[B_TMOUT], timeout_det, timeout_clear);
      flags[B_PECERR] <= flag_next(flags[B_PECERR], check_error_det, check_error_clear);
      flags[B_OVUN] <= flag_next(flags[B_OVUN], over_under_det, over_under_clear);
      flags[B_ARLOST] <= flag_next(flags[B_ARLOST], arb_lost_det, arb_lost_clear);
      flags[B_BUS_ERROR_FLAG] <= flag_next(flags[B_BUS_ERROR_FLAG], bus_error_det, bus_error_clear);
    end
  end

  // Reserved position inside the flag word stays zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[14] <= 1'b0;
    end else begin
      flags[14] <= next_flag_word;
    end
  end

  // Reload wait: set at the last byte of a reloaded chunk, cleared by a new count.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[B_RELOAD] <= 1'b0;
    end else begin
      flags[B_RELOAD] <= flag_next(flags[B_RELOAD], set_reload, wr_count);
    end
  end

  // Transfer done: a START or STOP clears it, but the set term wins if still true.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[B_DONE] <= 1'b0;
    end else begin
      flags[B_DONE] <= flag_next(flags[B_DONE], set_done, start_det || stop_det);
    end
  end

  // Stop, nack and address-match flags are sticky until software clears them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[B_STOP] <= 1'b0;
      flags[B_NACK] <= 1'b0;
      flags[B_ADDR] <= 1'b0;
    end else begin
      flags[B_STOP] <= flag_next(flags[B_STOP], stop_det, stop_seen_clear);
      flags[B_NACK] <= flag_next(flags[B_NACK], nack_det, nack_clear);
      flags[B_ADDR] <= flag_next(flags[B_ADDR], addr_match_det, addr_match_clear);
    end
  end

  // Receive full: set by a new byte, cleared when software reads the byte.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[B_RXFULL] <= 1'b0;
    end else begin
      flags[B_RXFULL] <= flag_next(flags[B_RXFULL], rx_byte_valid, rd_rx);
    end
  end

  // Transmit request: set when the byte moves on, or by a write of one while
  // stretching is off so software can preload; a new transmit byte retires it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[B_TXREQ] <= 1'b0;
    end else begin
      flags[B_TXREQ] <= flag_next(flags[B_TXREQ],
        tx_shift_load || (wr_status && hwdata[B_TXREQ] && stretch_disable), wr_tx);
    end
  end

  // Transmit empty: the shifter taking the byte or a flush write empties it.
  // Only these two status bits react to status writes; the rest ignore them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags[B_TXEMPTY] <= 1'b0;
    end else begin
      flags[B_TXEMPTY] <= flag_next(flags[B_TXEMPTY],
        tx_shift_load || (wr_status && hwdata[B_TXEMPTY]), wr_tx);
    end
  end

  // The bus-facing side sees a byte as valid while the register is not empty.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_byte_valid <= 1'b0;
    end else begin
      tx_byte_valid <= flag_next(tx_byte_valid, wr_tx,
        tx_shift_load || (wr_status && hwdata[B_TXEMPTY]));
    end
  end

  // Event bits latch each rising flag; writing one clears, a new rise wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_prev <= FLAGS_RESET;
      irq_status <= FLAGS_RESET;
    end else begin
      flags_prev <= flags;
      for (int i = 0; i < FLAG_W; i++) begin
        irq_status[i] <= flag_next(irq_status[i], flags[i] && !flags_prev[i],
          wr_irq_status && hwdata[i]);
      end
    end
  end

  // Mask register uses the same layout as the event bits.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= FLAGS_RESET;
    end else if (wr_irq_mask) begin
      irq_mask <= hwdata[FLAG_W-1:0];
    end
  end

  // Level interrupt, registered; it lags the event bits by one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Size and the upper address bits are not decoded; only whole words are used.
  logic unused_bits;
  assign unused_bits = ^{haddr[31:8], hsize};

endmodule
`default_nettype wire
